// >>> logic/dmx_pkg.sv
// Package for the data-move execution block: widths, opcode patterns,
// field positions, reset values and the decoded instruction kinds.
// Assumes a 14-bit program word and an 8-bit data path with 128 file registers.
package dmx_pkg;

	// ---------------------------------------------------------------
	// Widths
	// ---------------------------------------------------------------
	localparam int INSTR_W = 14;
	localparam int DATA_W  = 8;
	localparam int FADDR_W = 7;

	// ---------------------------------------------------------------
	// Opcode patterns and masks (match when (word & mask) == pattern)
	// ---------------------------------------------------------------
	localparam logic [13:0] MOVE_PAT   = 14'h0800;
	localparam logic [13:0] MOVE_MASK  = 14'h3F00;
	localparam logic [13:0] STORE_PAT  = 14'h0080;
	localparam logic [13:0] STORE_MASK = 14'h3F80;
	localparam logic [13:0] LOAD_PAT   = 14'h3000;
	localparam logic [13:0] LOAD_MASK  = 14'h3C00;
	localparam logic [13:0] IDLE_PAT   = 14'h0000;
	localparam logic [13:0] IDLE_MASK  = 14'h3F9F;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int FADDR_LSB = 0;
	localparam int DEST_BIT  = 7;
	localparam int LIT_LSB   = 0;

	// Destination bit values
	localparam logic DEST_WORK = 1'b0;
	localparam logic DEST_FILE = 1'b1;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] WORK_RST = 8'h00;
	localparam logic       ZERO_RST = 1'b0;
	localparam logic [6:0] FADDR_RST = 7'h00;
	localparam logic [7:0] DATA_RST = 8'h00;

	// ---------------------------------------------------------------
	// Decoded instruction kinds
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		DMX_IDLE_OP  = 3'b000,
		DMX_MOVE_OP  = 3'b001,
		DMX_STORE_OP = 3'b010,
		DMX_LOAD_OP  = 3'b011,
		DMX_OTHER_OP = 3'b100
	} dmx_kind_t;

endpackage : dmx_pkg

// >>> logic/dmx_if.sv
// Carrier between the decode stage and the execute stage.
// Assumes both ends share one clock; all fields come from decode flops.
`timescale 1ns/1ps
interface dmx_if
	import dmx_pkg::*;
();
	logic               valid;
	dmx_kind_t          kind;
	logic [FADDR_W-1:0] faddr;
	logic               dest;
	logic [DATA_W-1:0]  lit;

	modport dec (output valid, output kind, output faddr, output dest, output lit);
	modport exe (input valid, input kind, input faddr, input dest, input lit);
endinterface : dmx_if

// >>> logic/dmx_decode.sv
// Decode stage of the data-move execution block.
// Assumes one instruction word per clock, qualified by a valid strobe.
`timescale 1ns/1ps
module dmx_decode
	import dmx_pkg::*;
(
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire logic               valid_i,
	input  wire logic [INSTR_W-1:0] instr_i,
	dmx_if.dec                      bus
);

	logic      next_valid;
	dmx_kind_t next_kind;
	logic [FADDR_W-1:0] next_faddr;
	logic      next_dest;
	logic [DATA_W-1:0]  next_lit;

	// ---------------------------------------------------------------
	// Opcode match
	// ---------------------------------------------------------------
	// Operand don't-care bits are ignored here, so a word with stray
	// ones in them still decodes rather than faulting.
	always_comb
	begin
		next_valid = valid_i;
		next_faddr = instr_i[FADDR_LSB +: FADDR_W];
		next_dest  = instr_i[DEST_BIT];
		next_lit   = instr_i[LIT_LSB +: DATA_W];
		if ((instr_i & MOVE_MASK) == MOVE_PAT)
			next_kind = DMX_MOVE_OP;
		else if ((instr_i & STORE_MASK) == STORE_PAT)
			next_kind = DMX_STORE_OP;
		else if ((instr_i & LOAD_MASK) == LOAD_PAT)
			next_kind = DMX_LOAD_OP;
		else if ((instr_i & IDLE_MASK) == IDLE_PAT)
			next_kind = DMX_IDLE_OP;
		else
			next_kind = DMX_OTHER_OP;
	end

	// Stage registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			bus.valid <= 1'b0;
			bus.kind  <= DMX_IDLE_OP;
			bus.faddr <= FADDR_RST;
			bus.dest  <= DEST_WORK;
			bus.lit   <= DATA_RST;
		end
		else
		begin
			bus.valid <= next_valid;
			bus.kind  <= next_kind;
			bus.faddr <= next_faddr;
			bus.dest  <= next_dest;
			bus.lit   <= next_lit;
		end
	end

endmodule : dmx_decode

// >>> logic/dmx_exec.sv
// Execute stage and top of the data-move execution block: working
// register, zero flag and the file-register read and write ports.
// Assumes an external file register array with a combinational read
// port and a write port that commits on the clock edge.
`timescale 1ns/1ps

// Functional notes
// - Move-file copies f to working register if d=0, back into f if d=1.
// - Move-file sets zero flag from moved value, also when d=1.
// - Store-working writes working register into f (0..127); flags untouched.
// - Load-literal puts 8-bit immediate into working register; flags untouched.
module dmx_exec
	import dmx_pkg::*;
(
	input  wire logic               SYS_CLK_I,
	input  wire logic               RST_I,
	input  wire logic               INSTR_VALID_I,
	input  wire logic [INSTR_W-1:0] INSTR_I,
	output wire logic [FADDR_W-1:0] FILE_RADDR_O,
	input  wire logic [DATA_W-1:0]  FILE_RDATA_I,
	output wire logic               FILE_WE_O,
	output wire logic [FADDR_W-1:0] FILE_WADDR_O,
	output wire logic [DATA_W-1:0]  FILE_WDATA_O,
	output wire logic [DATA_W-1:0]  WORK_O,
	output wire logic               ZERO_O,
	output wire logic               DONE_O,
	output wire logic               UNKNOWN_O
);

	// ---------------------------------------------------------------
	// Decode stage
	// ---------------------------------------------------------------
	dmx_if stage ();

	dmx_decode u_decode (
		.clk_i   (SYS_CLK_I),
		.rst_i   (RST_I),
		.valid_i (INSTR_VALID_I),
		.instr_i (INSTR_I),
		.bus     (stage.dec)
	);

	// Read address comes straight from the decode flops
	assign FILE_RADDR_O = stage.faddr;

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic [DATA_W-1:0]  work;
	logic               zero;
	logic               file_we;
	logic [FADDR_W-1:0] file_waddr;
	logic [DATA_W-1:0]  file_wdata;
	logic               done;
	logic               unknown;

	logic [DATA_W-1:0]  next_work;
	logic               next_zero;
	logic               next_file_we;
	logic [FADDR_W-1:0] next_file_waddr;
	logic [DATA_W-1:0]  next_file_wdata;
	logic               next_done;
	logic               next_unknown;

	logic [DATA_W-1:0]  src_data;

	// ---------------------------------------------------------------
	// Source operand with write forwarding
	// ---------------------------------------------------------------
	// The write issued last cycle commits at this edge, so the array
	// still shows the old byte; forward it to keep back-to-back
	// store/move pairs on the same register coherent.
	always_comb
	begin
		if (file_we && (file_waddr == stage.faddr))
			src_data = file_wdata;
		else
			src_data = FILE_RDATA_I;
	end

	// ---------------------------------------------------------------
	// Working register and zero flag
	// ---------------------------------------------------------------
	// Only move and load touch this group; store, idle and words
	// outside the group hold both, so the flag stays as software
	// left it. One instruction retires per cycle.
	always_comb
	begin
		next_work = work;
		next_zero = zero;
		if (stage.valid)
		begin
			unique case (stage.kind)
				DMX_MOVE_OP:
				begin
					if (stage.dest == DEST_WORK)
						next_work = src_data;
					// Flag follows the moved byte, also when it goes back to f
					next_zero = (src_data == DATA_RST);
				end
				DMX_LOAD_OP:
				begin
					next_work = stage.lit;
				end
				DMX_STORE_OP:
				begin
					// Flags deliberately not touched
					next_zero = zero;
				end
				DMX_IDLE_OP:
				begin
					next_work = work;
				end
				DMX_OTHER_OP:
				begin
					next_work = work;
				end
				default:
				begin
					next_work = work;
				end
			endcase
		end
	end

	// Accumulator registers
	always_ff @(posedge SYS_CLK_I)
	begin
		if (RST_I)
		begin
			work <= WORK_RST;
			zero <= ZERO_RST;
		end
		else
		begin
			work <= next_work;
			zero <= next_zero;
		end
	end

	// ---------------------------------------------------------------
	// File write port
	// ---------------------------------------------------------------
	// Address and data hold between writes so only the enable pulses;
	// fewer toggles on the array bus at the cost of two holding flops.
	always_comb
	begin
		next_file_we    = 1'b0;
		next_file_waddr = file_waddr;
		next_file_wdata = file_wdata;
		if (stage.valid)
		begin
			unique case (stage.kind)
				DMX_MOVE_OP:
				begin
					if (stage.dest == DEST_FILE)
					begin
						next_file_we    = 1'b1;
						next_file_waddr = stage.faddr;
						next_file_wdata = src_data;
					end
				end
				DMX_STORE_OP:
				begin
					next_file_we    = 1'b1;
					next_file_waddr = stage.faddr;
					next_file_wdata = work;
				end
				DMX_LOAD_OP:
				begin
					next_file_we = 1'b0;
				end
				DMX_IDLE_OP:
				begin
					next_file_we = 1'b0;
				end
				DMX_OTHER_OP:
				begin
					next_file_we = 1'b0;
				end
				default:
				begin
					next_file_we = 1'b0;
				end
			endcase
		end
	end

	// Write port registers
	always_ff @(posedge SYS_CLK_I)
	begin
		if (RST_I)
		begin
			file_we    <= 1'b0;
			file_waddr <= FADDR_RST;
			file_wdata <= DATA_RST;
		end
		else
		begin
			file_we    <= next_file_we;
			file_waddr <= next_file_waddr;
			file_wdata <= next_file_wdata;
		end
	end

	// ---------------------------------------------------------------
	// Retire flags
	// ---------------------------------------------------------------
	// Exactly one of the two pulses per valid word; an illegal kind
	// code is reported like a foreign word rather than retired.
	always_comb
	begin
		next_done    = 1'b0;
		next_unknown = 1'b0;
		if (stage.valid)
		begin
			unique case (stage.kind)
				DMX_MOVE_OP, DMX_STORE_OP, DMX_LOAD_OP, DMX_IDLE_OP:
				begin
					next_done = 1'b1;
				end
				DMX_OTHER_OP:
				begin
					// Outside this group: retire nothing, flag it
					next_unknown = 1'b1;
				end
				default:
				begin
					next_unknown = 1'b1;
				end
			endcase
		end
	end

	// Retire registers
	always_ff @(posedge SYS_CLK_I)
	begin
		if (RST_I)
		begin
			done    <= 1'b0;
			unknown <= 1'b0;
		end
		else
		begin
			done    <= next_done;
			unknown <= next_unknown;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign FILE_WE_O    = file_we;
	assign FILE_WADDR_O = file_waddr;
	assign FILE_WDATA_O = file_wdata;
	assign WORK_O       = work;
	assign ZERO_O       = zero;
	assign DONE_O       = done;
	assign UNKNOWN_O    = unknown;

endmodule : dmx_exec

// >>> tb/dmx_exec_monitor.sv
// Checker for dmx_exec: retire latency, file writes and flag updates.
// Assumes file read data comes from a bypassed array beside the block.
`timescale 1ns/1ps
module dmx_exec_monitor
	import dmx_pkg::*;
(
	input wire logic               SYS_CLK_I,
	input wire logic               RST_I,
	input wire logic               INSTR_VALID_I,
	input wire logic [INSTR_W-1:0] INSTR_I,
	input wire logic [FADDR_W-1:0] FILE_RADDR_O,
	input wire logic [DATA_W-1:0]  FILE_RDATA_I,
	input wire logic               FILE_WE_O,
	input wire logic [FADDR_W-1:0] FILE_WADDR_O,
	input wire logic [DATA_W-1:0]  FILE_WDATA_O,
	input wire logic [DATA_W-1:0]  WORK_O,
	input wire logic               ZERO_O,
	input wire logic               DONE_O,
	input wire logic               UNKNOWN_O
);
	// ----------------------------------------
	// Decode of the word at the port
	// ----------------------------------------
	wire logic mv = INSTR_VALID_I && (INSTR_I & MOVE_MASK) == MOVE_PAT;
	wire logic st = INSTR_VALID_I && (INSTR_I & STORE_MASK) == STORE_PAT;
	wire logic ld = INSTR_VALID_I && (INSTR_I & LOAD_MASK) == LOAD_PAT;
	wire logic id = INSTR_VALID_I && (INSTR_I & IDLE_MASK) == IDLE_PAT;
	wire logic ot = INSTR_VALID_I && !mv && !st && !ld && !id;

	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (RST_I);

	// ----------------------------------------
	// Properties, two edges from take to retire
	// ----------------------------------------
	move_work_a: assert property (mv && !INSTR_I[7] |-> ##1 FILE_RADDR_O == $past(INSTR_I[6:0])
		##1 WORK_O == $past(FILE_RDATA_I) && !FILE_WE_O) else $error("move to work wrong");
	move_file_a: assert property (mv && INSTR_I[7] |-> ##2 FILE_WE_O && $stable(WORK_O)
		&& FILE_WDATA_O == $past(FILE_RDATA_I)) else $error("move to file wrong");
	move_zero_a: assert property (mv |-> ##2 ZERO_O == ($past(FILE_RDATA_I) == 8'h00))
		else $error("zero flag wrong");
	store_write_a: assert property (st |-> ##2 FILE_WE_O && FILE_WDATA_O == $past(WORK_O)
		&& FILE_WADDR_O == $past(INSTR_I[6:0], 2)) else $error("store write wrong");
	store_flag_a: assert property (st |-> ##2 $stable(ZERO_O) && $stable(WORK_O))
		else $error("store changed state");
	load_work_a: assert property (ld |-> ##2 WORK_O == $past(INSTR_I[7:0], 2) && $stable(ZERO_O))
		else $error("load wrong");
	retire_one_a: assert property (mv || st || ld || id |-> ##2 DONE_O)
		else $error("no retire pulse");
	idle_quiet_a: assert property (id |-> ##2 !FILE_WE_O && $stable(WORK_O) && $stable(ZERO_O))
		else $error("idle changed state");
	other_word_a: assert property (ot |-> ##2 UNKNOWN_O && !DONE_O && !FILE_WE_O
		&& $stable(WORK_O) && $stable(ZERO_O)) else $error("foreign word changed state");
	retire_excl_a: assert property (!(DONE_O && UNKNOWN_O))
		else $error("done and unknown together");

	// Main scenarios seen
	cover property (mv && INSTR_I[7]);
	cover property (st ##1 mv);
	cover property (ld ##1 ld);
	cover property (ot);
endmodule : dmx_exec_monitor

bind dmx_exec dmx_exec_monitor mon_u (.*);

// >>> tb/dmx_exec_tb.sv
// Bench for dmx_exec: corner words, then seeded random words.
// Assumes the file array lives here, with write-to-read bypass.
`timescale 1ns/1ps
module dmx_exec_tb;
	import dmx_pkg::*;
	logic               SYS_CLK_I = 1'b0;
	logic               RST_I     = 1'b1;
	logic               vld       = 1'b0;
	logic [INSTR_W-1:0] ins       = 14'h0000;
	wire logic [6:0]    raddr;
	wire logic [6:0]    waddr;
	wire logic [7:0]    rdata;
	wire logic [7:0]    wdata;
	wire logic [7:0]    work;
	wire logic          we;
	wire logic          zero;
	wire logic          done;
	wire logic          unk;
	logic [7:0]         mem [128];
	logic [7:0]         em [128];
	logic [14:0]        q1, q2;
	logic [7:0]         w, m;
	logic [6:0]         f;
	logic               z, wr;
	logic [31:0]        r;
	int unsigned        s;
	dmx_kind_t          k;
	int                 n_fail = 0;
	int                 compares = 0;
	logic [13:0] pat [4] = '{IDLE_PAT, MOVE_PAT, STORE_PAT, LOAD_PAT};
	logic [13:0] msk [4] = '{IDLE_MASK, MOVE_MASK, STORE_MASK, LOAD_MASK};
	logic [13:0] corner [10] = '{14'h3000, 14'h0800, 14'h00FF, 14'h30A5, 14'h00A0,
		14'h08A0, 14'h0060, 14'h3FFF, 14'h08FF, 14'h087F};

	dmx_exec dut_u (.SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .INSTR_VALID_I(vld),
		.INSTR_I(ins), .FILE_RADDR_O(raddr), .FILE_RDATA_I(rdata), .FILE_WE_O(we),
		.FILE_WADDR_O(waddr), .FILE_WDATA_O(wdata), .WORK_O(work), .ZERO_O(zero),
		.DONE_O(done), .UNKNOWN_O(unk));

	initial forever #4 SYS_CLK_I = ~SYS_CLK_I;

	// ----------------------------------------
	// File array and expectation helpers
	// ----------------------------------------
	// Bypass so a read in the cycle of a write sees the new byte
	assign rdata = (we && waddr == raddr) ? wdata : mem[raddr];

	function automatic dmx_kind_t kind(input logic [13:0] x);
		for (int i = 0; i < 4; i++)
			if ((x & msk[i]) == pat[i])
				return dmx_kind_t'(3'(i));
		return DMX_OTHER_OP;
	endfunction : kind

	task automatic chk(input logic ok);
		compares++;
		if (ok !== 1'b1)
		begin
			n_fail++;
			$display("MISMATCH %0t word %h", $time, q2);
		end
	endtask : chk

	task automatic issue(input logic v, input logic [13:0] x);
		@(posedge SYS_CLK_I);
		vld <= v;
		ins <= x;
	endtask : issue

	task automatic close_out();
		if (n_fail == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : close_out

	// Array write and a two-stage copy of the taken words
	always @(posedge SYS_CLK_I)
	begin
		if (we)
			mem[waddr] <= wdata;
		q2 <= RST_I ? 15'h0000 : q1;
		q1 <= RST_I ? 15'h0000 : {vld, ins};
	end

	// Retire the older word in the model and compare at mid-cycle
	always @(negedge SYS_CLK_I)
	begin
		k = kind(q2[13:0]);
		f = q2[6:0];
		m = em[f];
		wr = 1'b0;
		if (RST_I)
		begin
			w = WORK_RST;
			z = ZERO_RST;
		end
		else
		begin
			if (q2[14])
				case (k)
					DMX_MOVE_OP:  begin z = (m == 8'h00); wr = q2[7]; if (!q2[7]) w = m; end
					DMX_STORE_OP: begin wr = 1'b1; m = w; em[f] = w; end
					DMX_LOAD_OP:  w = q2[7:0];
					default:      ;
				endcase
			chk(work === w && zero === z && we === wr);
			chk(done === (q2[14] && k != DMX_OTHER_OP) && unk === (q2[14] && k == DMX_OTHER_OP));
			if (wr)
				chk(waddr === f && wdata === m);
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		void'($urandom(86912));
		for (int i = 0; i < 128; i++)
		begin
			mem[i] = (i == 0) ? 8'h00 : 8'($urandom);
			em[i] = mem[i];
		end
		repeat (10) @(posedge SYS_CLK_I);
		RST_I <= 1'b0;
		foreach (corner[j])
			issue(1'b1, corner[j]);
		repeat (800)
		begin
			r = $urandom;
			s = $urandom % 5;
			issue(r[31:30] != 2'b00, s < 4 ? pat[s] | (r[13:0] & ~msk[s]) : r[13:0]);
		end
		issue(1'b0, 14'h0000);
		repeat (3) @(posedge SYS_CLK_I);
		foreach (mem[i])
			chk(mem[i] === em[i]);
		close_out();
	end
endmodule : dmx_exec_tb
